// ---- pc_stack_defs.svh ----
/*
 * Offsets, field positions, reset values and stack index values of the
 * program counter and return-address stack unit.
 * Assumes a 12-bit register address and 8-bit register data.
 */
`ifndef PC_STACK_DEFS_SVH
`define PC_STACK_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCS_ADDR_PC_LOW 12'h002
`define PCS_ADDR_POWER_CTRL 12'h010
`define PCS_ADDR_STATUS_SHADOW 12'hfe4
`define PCS_ADDR_ACC_SHADOW 12'hfe5
`define PCS_ADDR_BANK_SHADOW 12'hfe6
`define PCS_ADDR_LATCH_SHADOW 12'hfe7
`define PCS_ADDR_PTR0_LOW_SHADOW 12'hfe8
`define PCS_ADDR_PTR0_HIGH_SHADOW 12'hfe9
`define PCS_ADDR_PTR1_LOW_SHADOW 12'hfea
`define PCS_ADDR_PTR1_HIGH_SHADOW 12'hfeb
`define PCS_ADDR_STACK_INDEX 12'hfed
`define PCS_ADDR_TOS_LOW 12'hfee
`define PCS_ADDR_TOS_HIGH 12'hfef

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define PCS_POWER_OVF_BIT 7
`define PCS_POWER_UNF_BIT 6
`define PCS_PC_RESET 15'h0000
`define PCS_INDEX_EMPTY 5'h1f
`define PCS_INDEX_LAST 5'h0f
`define PCS_INDEX_FIRST 5'h00
`define PCS_INT_VECTOR 15'h0004

`endif

// ---- pc_stack_pkg.sv ----
/*
 * Types shared by the program counter and stack unit.
 * Assumes pc_stack_defs.svh supplies the numeric constants.
 */
package pc_stack_pkg;

   // Operation requested by the instruction decoder in one cycle
   typedef enum logic [3:0] {
      OP_HOLD = 4'b0000,
      OP_NEXT = 4'b0001,
      OP_WRITE_PC_LOW = 4'b0010,
      OP_CALL = 4'b0011,
      OP_CALL_VIA_ACCUMULATOR = 4'b0100,
      OP_BRANCH_BY_ACCUMULATOR = 4'b0101,
      OP_BRANCH_RELATIVE = 4'b0110,
      OP_RETURN = 4'b0111,
      OP_RETURN_WITH_LITERAL = 4'b1000,
      OP_RETURN_FROM_INTERRUPT = 4'b1001,
      OP_INTERRUPT = 4'b1010
   } pc_op_t;

endpackage : pc_stack_pkg

// ---- pc_stack.sv ----
/*
 * Program counter sequencing, 16-entry return-address stack, stack
 * fault detection and core context shadows, with a plain register port.
 * Assumes the decoder, the pc_high_latch and the context inputs run on
 * clk_i; the register port reads back one cycle after the read strobe.
 */
// Function
// - 15-bit counter, low byte software accessible
// - Upper seven bits only via high latch
// - Any reset clears whole counter
// - Low-byte write loads upper bits from latch
// - Call: operand low 11, latch bits 6..3
// - Accumulator call: accumulator low, latch high
// - Accumulator branch: counter plus one plus accumulator
// - Relative branch: plus one plus signed operand
// - Sixteen entries of 15 bits, own space
// - Push on calls/interrupt, pop on returns
// - Push and pop leave latch untouched
// - Fault reset off: stack wraps circularly
// - Overflow and underflow flags always set
// - Index selects entry shown in top registers
// - Stack index is five bits wide
// - Increment then write; read then decrement
// - Empty index all ones; first push zero
// - Context shadows survive non-power-on resets
// - Fault reset on: reset and set flag
`timescale 1ns/1ps
`include "pc_stack_defs.svh"

module pc_stack #(
   parameter int DEPTH = 16,
   parameter logic [14:0] INT_VECTOR = `PCS_INT_VECTOR
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic power_on_reset_i,
   input wire logic ce_i,
   // Configuration
   input wire logic stack_fault_reset_enable_i,
   // Decoder request
   input wire pc_stack_pkg::pc_op_t op_i,
   input wire logic [10:0] call_operand_i,
   input wire logic [8:0] branch_operand_i,
   input wire logic [7:0] result_i,
   input wire logic [7:0] accumulator_i,
   input wire logic [6:0] pc_high_latch_i,
   // Core context to save
   input wire logic [2:0] ctx_status_i,
   input wire logic [4:0] ctx_bank_i,
   input wire logic [15:0] ctx_ptr0_i,
   input wire logic [15:0] ctx_ptr1_i,
   // Register port
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   // Counter and stack state
   output logic [14:0] pc_o,
   output logic [4:0] stack_index_o,
   output logic stack_overflow_flag_o,
   output logic stack_underflow_flag_o,
   output logic stack_fault_reset_o,
   // Context restore
   output logic restore_o,
   output logic [2:0] status_flags_shadow_o,
   output logic [7:0] accumulator_shadow_o,
   output logic [4:0] bank_select_shadow_o,
   output logic [6:0] pc_high_latch_shadow_o,
   output logic [15:0] ptr0_shadow_o,
   output logic [15:0] ptr1_shadow_o
);

   initial begin
      if (DEPTH != 16) begin
         $error("pc_stack: DEPTH must be 16 for a five-bit index");
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic wr_pc_low;
   logic wr_power;
   logic wr_index;
   logic wr_tos_low;
   logic wr_tos_high;
   logic wr_stat_sh;
   logic wr_acc_sh;
   logic wr_bank_sh;
   logic wr_latch_sh;
   logic wr_p0l_sh;
   logic wr_p0h_sh;
   logic wr_p1l_sh;
   logic wr_p1h_sh;

   always_comb begin
      wr_pc_low = reg_we_i && (reg_addr_i == `PCS_ADDR_PC_LOW);
      wr_power = reg_we_i && (reg_addr_i == `PCS_ADDR_POWER_CTRL);
      wr_index = reg_we_i && (reg_addr_i == `PCS_ADDR_STACK_INDEX);
      wr_tos_low = reg_we_i && (reg_addr_i == `PCS_ADDR_TOS_LOW);
      wr_tos_high = reg_we_i && (reg_addr_i == `PCS_ADDR_TOS_HIGH);
      wr_stat_sh = reg_we_i && (reg_addr_i == `PCS_ADDR_STATUS_SHADOW);
      wr_acc_sh = reg_we_i && (reg_addr_i == `PCS_ADDR_ACC_SHADOW);
      wr_bank_sh = reg_we_i && (reg_addr_i == `PCS_ADDR_BANK_SHADOW);
      wr_latch_sh = reg_we_i && (reg_addr_i == `PCS_ADDR_LATCH_SHADOW);
      wr_p0l_sh = reg_we_i && (reg_addr_i == `PCS_ADDR_PTR0_LOW_SHADOW);
      wr_p0h_sh = reg_we_i && (reg_addr_i == `PCS_ADDR_PTR0_HIGH_SHADOW);
      wr_p1l_sh = reg_we_i && (reg_addr_i == `PCS_ADDR_PTR1_LOW_SHADOW);
      wr_p1h_sh = reg_we_i && (reg_addr_i == `PCS_ADDR_PTR1_HIGH_SHADOW);
   end

   // ----------------------------------------------------------------
   // Counter and stack index sequencing
   // ----------------------------------------------------------------
   logic [14:0] pc_q;
   logic [14:0] pc_d;
   logic [4:0] idx_q;
   logic [4:0] idx_d;
   logic ovf_q;
   logic ovf_d;
   logic unf_q;
   logic unf_d;
   logic fault_q;
   logic fault_d;
   logic restore_q;
   logic restore_d;
   logic push;
   logic [3:0] push_slot;
   logic [14:0] push_value;
   logic [14:0] stack_q [DEPTH];
   logic [14:0] tos;
   logic [14:0] pc_inc;
   logic set_ovf;
   logic set_unf;

   always_comb begin
      pc_inc = pc_q + 15'h0001;
      tos = stack_q[idx_q[3:0]];
   end

   always_comb begin
      pc_d = pc_q;
      idx_d = idx_q;
      fault_d = 1'b0;
      restore_d = 1'b0;
      push = 1'b0;
      push_slot = 4'h0;
      push_value = pc_inc;
      set_ovf = 1'b0;
      set_unf = 1'b0;
      if (wr_index) begin
         idx_d = reg_wdata_i[4:0];
      end
      if (wr_pc_low) begin
         pc_d = {pc_high_latch_i, reg_wdata_i};
      end
      case (op_i)
         pc_stack_pkg::OP_HOLD: begin
            pc_d = pc_d;
         end
         pc_stack_pkg::OP_NEXT: begin
            pc_d = pc_inc;
         end
         pc_stack_pkg::OP_WRITE_PC_LOW: begin
            pc_d = {pc_high_latch_i, result_i};
         end
         pc_stack_pkg::OP_BRANCH_BY_ACCUMULATOR: begin
            pc_d = pc_inc + {7'h00, accumulator_i};
         end
         pc_stack_pkg::OP_BRANCH_RELATIVE: begin
            pc_d = pc_inc + {{6{branch_operand_i[8]}}, branch_operand_i};
         end
         pc_stack_pkg::OP_CALL,
         pc_stack_pkg::OP_CALL_VIA_ACCUMULATOR,
         pc_stack_pkg::OP_INTERRUPT: begin
            // Interrupted instruction resumes, so its own address is saved
            push_value = (op_i == pc_stack_pkg::OP_INTERRUPT) ? pc_q : pc_inc;
            if (idx_q == `PCS_INDEX_LAST) begin
               set_ovf = 1'b1;
            end
            if (set_ovf && stack_fault_reset_enable_i) begin
               fault_d = 1'b1;
            end else begin
               idx_d = set_ovf ? `PCS_INDEX_FIRST : idx_q + 5'h01;
               push = 1'b1;
               push_slot = idx_d[3:0];
               if (op_i == pc_stack_pkg::OP_CALL) begin
                  pc_d = {pc_high_latch_i[6:3], call_operand_i};
               end else if (op_i == pc_stack_pkg::OP_CALL_VIA_ACCUMULATOR) begin
                  pc_d = {pc_high_latch_i, accumulator_i};
               end else begin
                  pc_d = INT_VECTOR;
               end
            end
         end
         pc_stack_pkg::OP_RETURN,
         pc_stack_pkg::OP_RETURN_WITH_LITERAL,
         pc_stack_pkg::OP_RETURN_FROM_INTERRUPT: begin
            if (idx_q == `PCS_INDEX_EMPTY) begin
               set_unf = 1'b1;
            end
            if (set_unf && stack_fault_reset_enable_i) begin
               fault_d = 1'b1;
            end else begin
               pc_d = tos;
               idx_d = set_unf ? {1'b0, idx_q[3:0] - 4'h1} : idx_q - 5'h01;
               restore_d = (op_i == pc_stack_pkg::OP_RETURN_FROM_INTERRUPT);
            end
         end
         default: begin
            pc_d = pc_q;
         end
      endcase
      ovf_d = set_ovf | (ovf_q & ~(wr_power & ~reg_wdata_i[`PCS_POWER_OVF_BIT]));
      unf_d = set_unf | (unf_q & ~(wr_power & ~reg_wdata_i[`PCS_POWER_UNF_BIT]));
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pc_q <= `PCS_PC_RESET;
         idx_q <= `PCS_INDEX_EMPTY;
         fault_q <= 1'b0;
         restore_q <= 1'b0;
      end else if (ce_i) begin
         pc_q <= pc_d;
         idx_q <= idx_d;
         fault_q <= fault_d;
         restore_q <= restore_d;
      end
   end

   // Flags must outlive the stack fault reset they cause
   always_ff @(posedge clk_i) begin
      if (!resetn_i && power_on_reset_i) begin
         ovf_q <= 1'b0;
         unf_q <= 1'b0;
      end else if (ce_i && resetn_i) begin
         ovf_q <= ovf_d;
         unf_q <= unf_d;
      end
   end

   // ----------------------------------------------------------------
   // Stack storage
   // ----------------------------------------------------------------
   genvar e;
   generate
      for (e = 0; e < DEPTH; e++) begin : g_entry
         logic [14:0] entry_d;
         always_comb begin
            entry_d = stack_q[e];
            if (push && (push_slot == 4'(e))) begin
               entry_d = push_value;
            end else if (wr_tos_low && (idx_q[3:0] == 4'(e))) begin
               entry_d = {stack_q[e][14:8], reg_wdata_i};
            end else if (wr_tos_high && (idx_q[3:0] == 4'(e))) begin
               entry_d = {reg_wdata_i[6:0], stack_q[e][7:0]};
            end
         end
         always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
               stack_q[e] <= 15'h0000;
            end else if (ce_i) begin
               stack_q[e] <= entry_d;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Context shadows
   // ----------------------------------------------------------------
   logic [2:0] stat_sh_q;
   logic [2:0] stat_sh_d;
   logic [7:0] acc_sh_q;
   logic [7:0] acc_sh_d;
   logic [4:0] bank_sh_q;
   logic [4:0] bank_sh_d;
   logic [6:0] latch_sh_q;
   logic [6:0] latch_sh_d;
   logic [15:0] p0_sh_q;
   logic [15:0] p0_sh_d;
   logic [15:0] p1_sh_q;
   logic [15:0] p1_sh_d;
   logic save;

   always_comb begin
      save = (op_i == pc_stack_pkg::OP_INTERRUPT) && push;
      stat_sh_d = stat_sh_q;
      acc_sh_d = acc_sh_q;
      bank_sh_d = bank_sh_q;
      latch_sh_d = latch_sh_q;
      p0_sh_d = p0_sh_q;
      p1_sh_d = p1_sh_q;
      if (save) begin
         stat_sh_d = ctx_status_i;
         acc_sh_d = accumulator_i;
         bank_sh_d = ctx_bank_i;
         latch_sh_d = pc_high_latch_i;
         p0_sh_d = ctx_ptr0_i;
         p1_sh_d = ctx_ptr1_i;
      end else begin
         if (wr_stat_sh) begin
            stat_sh_d = reg_wdata_i[2:0];
         end
         if (wr_acc_sh) begin
            acc_sh_d = reg_wdata_i;
         end
         if (wr_bank_sh) begin
            bank_sh_d = reg_wdata_i[4:0];
         end
         if (wr_latch_sh) begin
            latch_sh_d = reg_wdata_i[6:0];
         end
         if (wr_p0l_sh) begin
            p0_sh_d[7:0] = reg_wdata_i;
         end
         if (wr_p0h_sh) begin
            p0_sh_d[15:8] = reg_wdata_i;
         end
         if (wr_p1l_sh) begin
            p1_sh_d[7:0] = reg_wdata_i;
         end
         if (wr_p1h_sh) begin
            p1_sh_d[15:8] = reg_wdata_i;
         end
      end
   end

   // Cleared only by power-on; other resets leave them as they are
   always_ff @(posedge clk_i) begin
      if (!resetn_i && power_on_reset_i) begin
         stat_sh_q <= 3'h0;
         acc_sh_q <= 8'h00;
         bank_sh_q <= 5'h00;
         latch_sh_q <= 7'h00;
         p0_sh_q <= 16'h0000;
         p1_sh_q <= 16'h0000;
      end else if (ce_i && resetn_i) begin
         stat_sh_q <= stat_sh_d;
         acc_sh_q <= acc_sh_d;
         bank_sh_q <= bank_sh_d;
         latch_sh_q <= latch_sh_d;
         p0_sh_q <= p0_sh_d;
         p1_sh_q <= p1_sh_d;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   always_comb begin
      rdata_d = 8'h00;
      if (reg_re_i) begin
         case (reg_addr_i)
            `PCS_ADDR_PC_LOW: rdata_d = pc_q[7:0];
            `PCS_ADDR_POWER_CTRL: begin
               rdata_d[`PCS_POWER_OVF_BIT] = ovf_q;
               rdata_d[`PCS_POWER_UNF_BIT] = unf_q;
            end
            `PCS_ADDR_STATUS_SHADOW: rdata_d = {5'h00, stat_sh_q};
            `PCS_ADDR_ACC_SHADOW: rdata_d = acc_sh_q;
            `PCS_ADDR_BANK_SHADOW: rdata_d = {3'h0, bank_sh_q};
            `PCS_ADDR_LATCH_SHADOW: rdata_d = {1'b0, latch_sh_q};
            `PCS_ADDR_PTR0_LOW_SHADOW: rdata_d = p0_sh_q[7:0];
            `PCS_ADDR_PTR0_HIGH_SHADOW: rdata_d = p0_sh_q[15:8];
            `PCS_ADDR_PTR1_LOW_SHADOW: rdata_d = p1_sh_q[7:0];
            `PCS_ADDR_PTR1_HIGH_SHADOW: rdata_d = p1_sh_q[15:8];
            `PCS_ADDR_STACK_INDEX: rdata_d = {3'h0, idx_q};
            `PCS_ADDR_TOS_LOW: rdata_d = tos[7:0];
            `PCS_ADDR_TOS_HIGH: rdata_d = {1'b0, tos[14:8]};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_q <= 8'h00;
      end else if (ce_i) begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb begin
      reg_rdata_o = rdata_q;
      pc_o = pc_q;
      stack_index_o = idx_q;
      stack_overflow_flag_o = ovf_q;
      stack_underflow_flag_o = unf_q;
      stack_fault_reset_o = fault_q;
      restore_o = restore_q;
      status_flags_shadow_o = stat_sh_q;
      accumulator_shadow_o = acc_sh_q;
      bank_select_shadow_o = bank_sh_q;
      pc_high_latch_shadow_o = latch_sh_q;
      ptr0_shadow_o = p0_sh_q;
      ptr1_shadow_o = p1_sh_q;
   end

endmodule : pc_stack

// ---- pc_stack_sva.sv ----
/* Concurrent checks on the pc_stack ports.
   Assumes one clock domain; bound to every pc_stack instance. */
`timescale 1ns/1ps
`include "pc_stack_defs.svh"
module pc_stack_sva (
   // Clock, reset, configuration
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic stack_fault_reset_enable_i,
   // Requests
   input wire pc_stack_pkg::pc_op_t op_i,
   input wire logic [10:0] call_operand_i,
   input wire logic [8:0] branch_operand_i,
   input wire logic [7:0] accumulator_i,
   input wire logic [6:0] pc_high_latch_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   // State
   input wire logic [14:0] pc_o,
   input wire logic [4:0] stack_index_o,
   input wire logic stack_overflow_flag_o,
   input wire logic stack_fault_reset_o
);
   logic is_push, is_pop, full;
   logic [14:0] call_tgt, rel_off;
   assign is_push = op_i inside {pc_stack_pkg::OP_CALL, pc_stack_pkg::OP_INTERRUPT,
      pc_stack_pkg::OP_CALL_VIA_ACCUMULATOR};
   assign is_pop = op_i inside {pc_stack_pkg::OP_RETURN, pc_stack_pkg::OP_RETURN_WITH_LITERAL,
      pc_stack_pkg::OP_RETURN_FROM_INTERRUPT};
   assign full = stack_fault_reset_enable_i && stack_index_o == 5'h0f;
   assign call_tgt = {pc_high_latch_i[6:3], call_operand_i};
   assign rel_off = {{6{branch_operand_i[8]}}, branch_operand_i};
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   sequence push_ok_s;
      ce_i && is_push && stack_index_o != 5'h0f;
   endsequence
   sequence pop_ok_s;
      ce_i && is_pop && stack_index_o != 5'h1f;
   endsequence
   sequence ovf_s;
      ce_i && is_push && full;
   endsequence
   reset_clear_a: assert property ($rose(resetn_i) |-> pc_o == 15'h0000 &&
      stack_index_o == 5'h1f) else $error("reset state wrong");
   pc_write_a: assert property (ce_i && op_i == pc_stack_pkg::OP_HOLD && reg_we_i &&
      reg_addr_i == `PCS_ADDR_PC_LOW |=> pc_o == {$past(pc_high_latch_i), $past(reg_wdata_i)})
      else $error("low byte write wrong");
   call_tgt_a: assert property (ce_i && op_i == pc_stack_pkg::OP_CALL && !full
      |=> pc_o == $past(call_tgt)) else $error("call target wrong");
   acc_call_a: assert property (ce_i && op_i == pc_stack_pkg::OP_CALL_VIA_ACCUMULATOR &&
      !full |=> pc_o == {$past(pc_high_latch_i), $past(accumulator_i)})
      else $error("accumulator call wrong");
   acc_branch_a: assert property (ce_i && op_i == pc_stack_pkg::OP_BRANCH_BY_ACCUMULATOR
      |=> pc_o == $past(pc_o) + 15'h0001 + {7'h00, $past(accumulator_i)})
      else $error("accumulator branch wrong");
   rel_branch_a: assert property (ce_i && op_i == pc_stack_pkg::OP_BRANCH_RELATIVE
      |=> pc_o == $past(pc_o) + 15'h0001 + $past(rel_off)) else $error("branch wrong");
   next_inc_a: assert property (ce_i && op_i == pc_stack_pkg::OP_NEXT
      |=> pc_o == $past(pc_o) + 15'h0001) else $error("increment wrong");
   push_index_a: assert property (push_ok_s |=>
      stack_index_o == $past(stack_index_o) + 5'h01) else $error("push index wrong");
   pop_index_a: assert property (pop_ok_s |=>
      stack_index_o == $past(stack_index_o) - 5'h01) else $error("pop index wrong");
   ovf_fault_a: assert property (ovf_s |=> stack_fault_reset_o &&
      stack_overflow_flag_o && $stable(stack_index_o)) else $error("overflow fault wrong");
endmodule : pc_stack_sva

bind pc_stack pc_stack_sva u_sva (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
   .stack_fault_reset_enable_i(stack_fault_reset_enable_i), .op_i(op_i),
   .call_operand_i(call_operand_i), .branch_operand_i(branch_operand_i),
   .accumulator_i(accumulator_i), .pc_high_latch_i(pc_high_latch_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .pc_o(pc_o),
   .stack_index_o(stack_index_o), .stack_overflow_flag_o(stack_overflow_flag_o),
   .stack_fault_reset_o(stack_fault_reset_o));

// ---- pc_decoder_model.sv ----
/* Behavioural instruction decoder feeding pc_stack.
   Assumes the bench calls its tasks only after reset is released. */
`timescale 1ns/1ps
module decoder_model (
   // Clock
   input wire logic clk_i,
   // Decoder request
   output logic ce_o,
   output pc_stack_pkg::pc_op_t op_o,
   output logic [10:0] call_operand_o,
   output logic [8:0] branch_operand_o,
   output logic [7:0] result_o,
   output logic [7:0] accumulator_o,
   output logic [6:0] pc_high_latch_o
);
   initial begin
      ce_o = 1'b1;
      op_o = pc_stack_pkg::OP_HOLD;
      call_operand_o = 11'h000;
      branch_operand_o = 9'h000;
      result_o = 8'h00;
      accumulator_o = 8'h00;
      pc_high_latch_o = 7'h00;
   end
   task automatic set_latch(input logic [6:0] l);
      @(posedge clk_i);
      pc_high_latch_o <= l;
   endtask : set_latch
   // One op for one cycle, then idle with call, branch and result operands inverted, accumulator held
   task automatic run(input pc_stack_pkg::pc_op_t o, input logic [10:0] c,
      input logic [8:0] b, input logic [7:0] a);
      @(posedge clk_i);
      op_o <= o;
      call_operand_o <= c;
      branch_operand_o <= b;
      result_o <= a;
      accumulator_o <= a;
      @(posedge clk_i);
      op_o <= pc_stack_pkg::OP_HOLD;
      call_operand_o <= ~c;
      branch_operand_o <= ~b;
      result_o <= ~a;
      #1;
   endtask : run
   // One op presented while the enable is low
   task automatic frozen(input pc_stack_pkg::pc_op_t o);
      @(posedge clk_i);
      ce_o <= 1'b0;
      op_o <= o;
      @(posedge clk_i);
      ce_o <= 1'b1;
      op_o <= pc_stack_pkg::OP_HOLD;
      #1;
   endtask : frozen
endmodule : decoder_model

// ---- pc_stack_tb.sv ----
/* Self-checking bench of pc_stack with a decoder model.
   Assumes the default interrupt vector and a sixteen-entry stack. */
`timescale 1ns/1ps
`include "pc_stack_defs.svh"
module pc_stack_tb;
   logic clk_i, resetn_i, por, fen, we, re, ce, ovf, unf, flt, rsto;
   logic [11:0] addr;
   logic [7:0] wd, rdata, res, acc;
   logic [14:0] pc;
   logic [4:0] idx;
   logic [10:0] cop;
   logic [8:0] bop;
   logic [6:0] lat;
   pc_stack_pkg::pc_op_t op;
   logic [2:0] cst, sst;
   logic [4:0] cbk, sbk;
   logic [7:0] sac;
   logic [6:0] slt;
   logic [15:0] cp0, cp1, sp0, sp1;
   int fail_count = 0;
   int num_checks = 0;
   pc_stack uut (.clk_i(clk_i), .resetn_i(resetn_i), .power_on_reset_i(por), .ce_i(ce),
      .stack_fault_reset_enable_i(fen), .op_i(op), .call_operand_i(cop),
      .branch_operand_i(bop), .result_i(res), .accumulator_i(acc), .pc_high_latch_i(lat),
      .ctx_status_i(cst), .ctx_bank_i(cbk), .ctx_ptr0_i(cp0), .ctx_ptr1_i(cp1),
      .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
      .pc_o(pc), .stack_index_o(idx), .stack_overflow_flag_o(ovf),
      .stack_underflow_flag_o(unf), .stack_fault_reset_o(flt), .restore_o(rsto),
      .status_flags_shadow_o(sst), .accumulator_shadow_o(sac), .bank_select_shadow_o(sbk),
      .pc_high_latch_shadow_o(slt), .ptr0_shadow_o(sp0), .ptr1_shadow_o(sp1));
   decoder_model dec (.clk_i(clk_i), .ce_o(ce), .op_o(op), .call_operand_o(cop),
      .branch_operand_o(bop), .result_o(res), .accumulator_o(acc), .pc_high_latch_o(lat));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic give_verdict;
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      we <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk_i);
      we <= 1'b0;
   endtask : wr
   task automatic rc(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_i);
      re <= 1'b1;
      addr <= a;
      @(posedge clk_i);
      re <= 1'b0;
      #1;
      chk(rdata, e);
   endtask : rc
   task automatic do_reset(input logic po);
      @(posedge clk_i);
      resetn_i <= 1'b0;
      por <= po;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      por <= 1'b0;
      #1;
      chk(pc, 15'h0000);
      chk(idx, 5'h1f);
   endtask : do_reset
   task automatic t_low_byte;
      dec.set_latch(7'h12);
      wr(`PCS_ADDR_PC_LOW, 8'h34);
      #1;
      chk(pc, 15'h1234);
      rc(`PCS_ADDR_PC_LOW, 8'h34);
      dec.set_latch(7'h7f);
      dec.run(pc_stack_pkg::OP_WRITE_PC_LOW, 11'h000, 9'h000, 8'hff);
      chk(pc, 15'h7fff);
      dec.run(pc_stack_pkg::OP_NEXT, 11'h000, 9'h000, 8'h00);
      chk(pc, 15'h0000);
   endtask : t_low_byte
   task automatic t_calls;
      dec.set_latch(7'h5a);
      dec.run(pc_stack_pkg::OP_CALL, 11'h123, 9'h000, 8'h00);
      chk(pc, {4'hb, 11'h123});
      chk(idx, 5'h00);
      rc(`PCS_ADDR_TOS_LOW, 8'h01);
      dec.run(pc_stack_pkg::OP_CALL_VIA_ACCUMULATOR, 11'h000, 9'h000, 8'h9c);
      chk(pc, 15'h5a9c);
      rc(`PCS_ADDR_TOS_HIGH, 8'h59);
      rc(`PCS_ADDR_STACK_INDEX, 8'h01);
      dec.run(pc_stack_pkg::OP_RETURN, 11'h000, 9'h000, 8'h00);
      chk(pc, 15'h5924);
      dec.run(pc_stack_pkg::OP_RETURN_WITH_LITERAL, 11'h000, 9'h000, 8'h00);
      chk(pc, 15'h0001);
      chk(idx, 5'h1f);
   endtask : t_calls
   task automatic t_branch;
      dec.run(pc_stack_pkg::OP_BRANCH_BY_ACCUMULATOR, 11'h000, 9'h000, 8'hff);
      chk(pc, 15'h0101);
      dec.run(pc_stack_pkg::OP_BRANCH_RELATIVE, 11'h000, 9'h100, 8'h00);
      chk(pc, 15'h0002);
      dec.run(pc_stack_pkg::OP_BRANCH_RELATIVE, 11'h000, 9'h0ff, 8'h00);
      chk(pc, 15'h0102);
      dec.frozen(pc_stack_pkg::OP_NEXT);
      chk(pc, 15'h0102);
   endtask : t_branch
   task automatic t_wrap;
      dec.set_latch(7'h00);
      for (int k = 0; k < 17; k++) dec.run(pc_stack_pkg::OP_CALL, 11'(k + 16), 9'h000, 8'h00);
      chk(idx, 5'h00);
      rc(`PCS_ADDR_TOS_LOW, 8'h20);
      chk(ovf, 1'b1);
      dec.run(pc_stack_pkg::OP_RETURN, 11'h000, 9'h000, 8'h00);
      dec.run(pc_stack_pkg::OP_RETURN, 11'h000, 9'h000, 8'h00);
      chk(unf, 1'b1);
      rc(`PCS_ADDR_POWER_CTRL, 8'hc0);
   endtask : t_wrap
   task automatic t_fault;
      @(posedge clk_i);
      fen <= 1'b1;
      do_reset(1'b1);
      for (int k = 0; k < 16; k++) dec.run(pc_stack_pkg::OP_CALL, 11'(k), 9'h000, 8'h00);
      dec.run(pc_stack_pkg::OP_CALL, 11'h7ff, 9'h000, 8'h00);
      chk(flt, 1'b1);
      chk(pc, 15'h000f);
      do_reset(1'b0);
      rc(`PCS_ADDR_POWER_CTRL, 8'h80);
      dec.run(pc_stack_pkg::OP_RETURN, 11'h000, 9'h000, 8'h00);
      chk(flt, 1'b1);
      chk(idx, 5'h1f);
      rc(`PCS_ADDR_POWER_CTRL, 8'hc0);
   endtask : t_fault
   task automatic t_tos;
      @(posedge clk_i);
      fen <= 1'b0;
      wr(`PCS_ADDR_STACK_INDEX, 8'h03);
      wr(`PCS_ADDR_TOS_HIGH, 8'h2a);
      wr(`PCS_ADDR_TOS_LOW, 8'h5c);
      rc(`PCS_ADDR_TOS_HIGH, 8'h2a);
      rc(`PCS_ADDR_TOS_LOW, 8'h5c);
      rc(12'hfec, 8'h00);
      dec.run(pc_stack_pkg::OP_RETURN, 11'h000, 9'h000, 8'h00);
      chk(pc, 15'h2a5c);
      chk(idx, 5'h02);
   endtask : t_tos
   task automatic t_shadow;
      dec.set_latch(7'h33);
      dec.run(pc_stack_pkg::OP_INTERRUPT, 11'h000, 9'h000, 8'hc3);
      chk(pc, `PCS_INT_VECTOR);
      rc(`PCS_ADDR_ACC_SHADOW, 8'hc3);
      rc(`PCS_ADDR_LATCH_SHADOW, 8'h33);
      rc(`PCS_ADDR_STATUS_SHADOW, 8'h05);
      rc(`PCS_ADDR_PTR0_HIGH_SHADOW, 8'h12);
      dec.run(pc_stack_pkg::OP_RETURN_FROM_INTERRUPT, 11'h000, 9'h000, 8'h00);
      chk(rsto, 1'b1);
      chk(pc, 15'h2a5c);
      chk({sst, sac, sbk}, {3'h5, 8'hc3, 5'h15});
      chk({9'h000, slt}, 16'h0033);
      chk(sp0, 16'h1234);
      chk(sp1, 16'h5678);
      do_reset(1'b0);
      rc(`PCS_ADDR_ACC_SHADOW, 8'hc3);
   endtask : t_shadow
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      give_verdict;
   end
   initial begin
      resetn_i = 1'b0;
      por = 1'b1;
      fen = 1'b0;
      addr = 12'h000;
      wd = 8'h00;
      we = 1'b0;
      re = 1'b0;
      cst = 3'h5;
      cbk = 5'h15;
      cp0 = 16'h1234;
      cp1 = 16'h5678;
      do_reset(1'b1);
      rc(`PCS_ADDR_ACC_SHADOW, 8'h00);
      t_low_byte;
      t_calls;
      t_branch;
      t_wrap;
      t_fault;
      t_tos;
      t_shadow;
      give_verdict;
   end
endmodule : pc_stack_tb
